// *** include/cbu_pkg.sv ***
/*
 Constants for the conditional branch unit: opcode fields, phase encoding,
 program counter width and reset values. Assumes a core with four clock
 phases per instruction cycle on one system clock.
*/
// Summary of operation
// - Negative set branches to target, else falls through.
// - Negative-set opcode is 1110 0110 plus displacement.
// - Opcode 1110 0011 branches when carry is 0.
// - Opcode 1110 0111 branches when negative is 0.
// - Opcode 1110 0101 branches when overflow is 0.
// - Displacement is signed, doubled, word aligned.
// - Target is branch address plus 2 plus 2n.
// - Adds to already incremented program counter.
// - Untaken leaves PC at address plus 2.
// - Taken costs two cycles, untaken costs one.
// - Taken: decode, read, process, write PC in Q4.
// - Taken second cycle is a no-op flush.
// - Untaken does no PC write in Q4.
package cbu_pkg;
   localparam int CBU_PC_WIDTH = 21;
   localparam int CBU_WORD_WIDTH = 16;
   localparam logic [3:0] CBU_GROUP_NIBBLE = 4'hE;
   localparam logic [3:0] CBU_SUB_NEG_SET = 4'h6;
   localparam logic [3:0] CBU_SUB_CARRY_CLEAR = 4'h3;
   localparam logic [3:0] CBU_SUB_NEG_CLEAR = 4'h7;
   localparam logic [3:0] CBU_SUB_OVF_CLEAR = 4'h5;
   localparam int CBU_GROUP_HI = 15;
   localparam int CBU_GROUP_LO = 12;
   localparam int CBU_SUB_HI = 11;
   localparam int CBU_SUB_LO = 8;
   localparam int CBU_DISP_HI = 7;
   localparam int CBU_DISP_LO = 0;
   localparam logic [20:0] CBU_PC_RESET = 21'h000000;
   localparam logic [1:0] CBU_PHASE_Q1 = 2'h0;
   localparam logic [1:0] CBU_PHASE_Q2 = 2'h1;
   localparam logic [1:0] CBU_PHASE_Q3 = 2'h2;
   localparam logic [1:0] CBU_PHASE_Q4 = 2'h3;
   typedef enum logic [1:0] {CBU_COND_NONE, CBU_COND_TRUE} cbu_dummy_type;
   typedef enum {CBU_EXECUTE, CBU_FLUSH} cbu_state_type;
endpackage

// *** rtl/cbu_core.sv ***
/*
 Conditional branch unit. Steps Q1..Q4 each clock, decodes the fetched word
 at Q1, and on a taken branch writes the PC at Q4 then flushes one cycle.
 Assumes the fetch stage supplies the word and advances the PC itself.
*/
`timescale 1ns/10ps
`default_nettype none
module cbu_core
   import cbu_pkg::*;
#(
   parameter int PC_WIDTH = CBU_PC_WIDTH
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [CBU_WORD_WIDTH-1:0] fetch_word,
   input wire logic flag_neg,
   input wire logic flag_carry,
   input wire logic flag_ovf,
   input wire logic [PC_WIDTH-1:0] pc_in,
   output logic [1:0] phase,
   output logic is_branch,
   output logic pc_write,
   output logic [PC_WIDTH-1:0] pc_out,
   output logic flush,
   output logic done
);
   cbu_state_type state;
   cbu_state_type next_state;
   logic [CBU_WORD_WIDTH-1:0] ir;
   logic hit;
   logic hold_taken;
   logic [7:0] disp;
   logic [PC_WIDTH-1:0] target;
   logic dec_branch;
   logic dec_taken;

   cbu_decoder u_dec (
      .word(fetch_word),
      .flag_neg(flag_neg),
      .flag_carry(flag_carry),
      .flag_ovf(flag_ovf),
      .is_branch(dec_branch),
      .taken(dec_taken)
   );

   cbu_target #(.PC_WIDTH(PC_WIDTH)) u_tgt (
      .pc_next(pc_in),
      .disp(disp),
      .target(target)
   );

   wire logic at_q1 = (phase == CBU_PHASE_Q1);
   wire logic at_q2 = (phase == CBU_PHASE_Q2);
   wire logic at_q4 = (phase == CBU_PHASE_Q4);
   wire logic run = (state == CBU_EXECUTE);
   wire logic write_now = at_q4 && run && hit && hold_taken;
   wire logic end_cycle = at_q4 && !write_now;

   always_comb begin
      next_state = state;
      case (state)
         CBU_EXECUTE: if (write_now) next_state = CBU_FLUSH;
         CBU_FLUSH: if (at_q4) next_state = CBU_EXECUTE;
         default: next_state = CBU_EXECUTE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         phase <= CBU_PHASE_Q1;
         state <= CBU_EXECUTE;
      end else begin
         phase <= phase + 2'h1;
         state <= next_state;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ir <= '0;
         hit <= 1'b0;
         hold_taken <= 1'b0;
      end else if (at_q1 && run) begin
         ir <= fetch_word;
         hit <= dec_branch;
         hold_taken <= dec_taken;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         disp <= 8'h00;
      end else if (at_q2 && run) begin
         disp <= ir[CBU_DISP_HI:CBU_DISP_LO];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pc_write <= 1'b0;
         pc_out <= PC_WIDTH'(CBU_PC_RESET);
         flush <= 1'b0;
         done <= 1'b0;
         is_branch <= 1'b0;
      end else begin
         pc_write <= write_now;
         if (write_now) begin
            pc_out <= target;
         end
         flush <= (next_state == CBU_FLUSH);
         done <= end_cycle && hit && run;
         is_branch <= hit && run;
      end
   end
endmodule
`default_nettype wire

// *** rtl/cbu_decoder.sv ***
/*
 Combinational decode of one instruction word into a branch condition.
 Assumes the word and flags are stable on the same clock as the core.
*/
`timescale 1ns/10ps
`default_nettype none
module cbu_decoder
   import cbu_pkg::*;
(
   input wire logic [CBU_WORD_WIDTH-1:0] word,
   input wire logic flag_neg,
   input wire logic flag_carry,
   input wire logic flag_ovf,
   output logic is_branch,
   output logic taken
);
   wire logic group_hit = (word[CBU_GROUP_HI:CBU_GROUP_LO] == CBU_GROUP_NIBBLE);
   wire logic [3:0] sub = word[CBU_SUB_HI:CBU_SUB_LO];
   wire logic branch_if_neg_set = group_hit && (sub == CBU_SUB_NEG_SET);
   wire logic branch_if_carry_clear = group_hit && (sub == CBU_SUB_CARRY_CLEAR);
   wire logic branch_if_neg_clear = group_hit && (sub == CBU_SUB_NEG_CLEAR);
   wire logic branch_if_ovf_clear = group_hit && (sub == CBU_SUB_OVF_CLEAR);
   assign is_branch = branch_if_neg_set | branch_if_carry_clear | branch_if_neg_clear
      | branch_if_ovf_clear;
   assign taken = (branch_if_neg_set && flag_neg)
      || (branch_if_carry_clear && !flag_carry)
      || (branch_if_neg_clear && !flag_neg)
      || (branch_if_ovf_clear && !flag_ovf);
endmodule
`default_nettype wire

// *** rtl/cbu_target.sv ***
/*
 Branch target adder: incremented PC plus twice the signed displacement.
 Assumes pc_next already points past the branch word.
*/
`timescale 1ns/10ps
`default_nettype none
module cbu_target
   import cbu_pkg::*;
#(
   parameter int PC_WIDTH = CBU_PC_WIDTH
) (
   input wire logic [PC_WIDTH-1:0] pc_next,
   input wire logic [7:0] disp,
   output logic [PC_WIDTH-1:0] target
);
   wire logic [PC_WIDTH-1:0] offset = PC_WIDTH'({{(PC_WIDTH-9){disp[7]}}, disp, 1'b0});
   assign target = pc_next + offset;
endmodule
`default_nettype wire

// *** verification/cbu_chk.sv ***
/* Checker for cbu_core, bound to its ports.
 Assumes one clock domain and an active-high asynchronous reset. */
`timescale 1ns/10ps
`default_nettype none
module cbu_chk
   import cbu_pkg::*;
#(
   parameter int PC_WIDTH = CBU_PC_WIDTH
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [CBU_WORD_WIDTH-1:0] fetch_word,
   input wire logic flag_neg,
   input wire logic flag_carry,
   input wire logic flag_ovf,
   input wire logic [PC_WIDTH-1:0] pc_in,
   input wire logic [1:0] phase,
   input wire logic is_branch,
   input wire logic pc_write,
   input wire logic [PC_WIDTH-1:0] pc_out,
   input wire logic flush,
   input wire logic done
);
   logic live;
   logic [7:0] d;
   wire logic [3:0] s = fetch_word[11:8];
   wire logic grp = fetch_word[15:12] == 4'hE && s inside {4'h3, 4'h5, 4'h6, 4'h7};
   wire logic tk = s == 4'h6 ? flag_neg : s == 4'h7 ? !flag_neg : s == 4'h3 ? !flag_carry : !flag_ovf;
   wire logic go = live && phase == 2'h0 && !flush;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) live <= 1'b0;
      else live <= 1'b1;
   end
   always_ff @(posedge clk_sys) begin
      if (go) d <= fetch_word[7:0];
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   a_phase_step: assert property (live |-> phase == 2'($past(phase) + 2'h1))
      else $error("phase skipped");
   a_taken_write: assert property (go && grp && tk |-> ##4 pc_write && flush)
      else $error("no PC write");
   a_untaken_done: assert property (go && grp && !tk |-> ##4 done && !pc_write)
      else $error("untaken wrong");
   a_foreign_quiet: assert property (go && !grp |-> ##4 !pc_write && !done)
      else $error("foreign word ran");
   a_target_value: assert property (pc_write |->
      pc_out == pc_in + {{(PC_WIDTH-9){d[7]}}, d, 1'b0}) else $error("bad target");
   a_write_pulse: assert property (pc_write |=> !pc_write && !done)
      else $error("long write");
   a_flush_span: assert property ($rose(flush) |->
      pc_write ##1 (flush && !pc_write)[*3] ##1 !flush) else $error("bad flush");
   a_pc_hold: assert property (!pc_write |-> $stable(pc_out))
      else $error("PC moved");
   a_branch_flag: assert property (go && grp |-> ##4 is_branch)
      else $error("branch flag low");
   a_flush_quiet: assert property (flush |-> !done)
      else $error("done during flush");
endmodule
bind cbu_core cbu_chk #(.PC_WIDTH(PC_WIDTH)) i_chk (.clk_sys, .rst, .fetch_word, .flag_neg,
   .flag_carry, .flag_ovf, .pc_in, .phase, .is_branch, .pc_write, .pc_out, .flush, .done);
`default_nettype wire

// *** verification/tb_conditional_branch_unit.sv ***
/* Bench for cbu_core: drives words and flags, judges PC outcomes.
 Assumes one instruction per four clocks. */
`timescale 1ns/10ps
`default_nettype none
module tb_conditional_branch_unit;
   logic clk_sys = 1'b0, rst = 1'b1, flag_neg = 1'b0, flag_carry = 1'b0, flag_ovf = 1'b0;
   logic [15:0] fetch_word = 16'h0000;
   logic [20:0] pc_in = 21'h000000, pc_out;
   logic [1:0] phase;
   logic is_branch, pc_write, flush, done;
   int error_cnt = 0, compares = 0;
   always #2.5 clk_sys = ~clk_sys;
   cbu_core i_dut (.clk_sys, .rst, .fetch_word, .flag_neg, .flag_carry, .flag_ovf, .pc_in,
      .phase, .is_branch, .pc_write, .pc_out, .flush, .done);
   task automatic chk(input logic [1:0] g, input logic [1:0] e);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %0t outcome %b", $time, g);
      end
   endtask
   task automatic chk_pc(input logic [20:0] g, input logic [20:0] e);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %0t pc %h", $time, g);
      end
   endtask
   task automatic run(input logic [7:0] op, input logic [7:0] n, input logic [2:0] f,
         input logic [20:0] a, input logic [1:0] e);
      {flag_neg, flag_carry, flag_ovf} = f;
      fetch_word = {op, n};
      pc_in = a + 21'h000002;
      repeat (4) @(posedge clk_sys);
      #1;
      chk({pc_write, done}, e);
      chk({1'b0, is_branch}, {1'b0, e != 2'h0});
      if (e[1]) begin
         chk_pc(pc_out, a + 21'h000002 + {{12{n[7]}}, n, 1'b0});
         repeat (4) @(posedge clk_sys);
         #1;
         chk({pc_write, done}, 2'h0);
      end
   endtask
   task automatic s_negative;
      run(8'hE6, 8'h7F, 3'b100, 21'h000100, 2'h2);
      run(8'hE6, 8'h80, 3'b011, 21'h000100, 2'h1);
      run(8'hE7, 8'h80, 3'b011, 21'h000100, 2'h2);
      run(8'hE7, 8'h01, 3'b100, 21'h000200, 2'h1);
   endtask
   task automatic s_carry_ovf;
      run(8'hE3, 8'h80, 3'b101, 21'h000100, 2'h2);
      run(8'hE3, 8'h7F, 3'b010, 21'h000100, 2'h1);
      run(8'hE5, 8'hFF, 3'b110, 21'h1FFFFE, 2'h2);
      run(8'hE5, 8'h00, 3'b001, 21'h000100, 2'h1);
   endtask
   task automatic s_foreign;
      run(8'hE4, 8'h10, 3'b111, 21'h000100, 2'h0);
      run(8'hE1, 8'h10, 3'b000, 21'h000100, 2'h0);
   endtask
   task automatic end_of_test;
      if (error_cnt == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      do begin
         @(posedge clk_sys);
         #1;
      end while (phase !== 2'h0);
      s_negative;
      s_carry_ovf;
      s_foreign;
      end_of_test;
   end
   initial begin
      #2000;
      error_cnt++;
      end_of_test;
   end
endmodule
`default_nettype wire
